// ==== core/sgp_pkg.sv ====
// Purpose: Constants and types for the six-bit general-purpose port
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: Register map, reset values and pad control struct
package sgp_pkg;
    localparam int NPIN = 6;
    localparam int AW = 8;
    localparam int INPUT_ONLY_BIT = 3;
    // Byte offsets
    localparam logic [7:0] OFS_PIN_VALUE = 8'h00;
    localparam logic [7:0] OFS_DIRECTION = 8'h04;
    localparam logic [7:0] OFS_OUTPUT_LATCH = 8'h08;
    localparam logic [7:0] OFS_ANALOG_SELECT = 8'h0C;
    localparam logic [7:0] OFS_PULLUP_ENABLE = 8'h10;
    localparam logic [7:0] OFS_OPEN_DRAIN = 8'h14;
    localparam logic [7:0] OFS_SLEW_LIMIT = 8'h18;
    localparam logic [7:0] OFS_INPUT_THRESHOLD = 8'h1C;
    localparam logic [7:0] OFS_PULLUP_CONTROL = 8'h20;
    // Implemented bits per register
    localparam logic [5:0] MASK_IO = 6'h37;
    localparam logic [5:0] MASK_ANALOG = 6'h17;
    localparam logic [5:0] MASK_ALL = 6'h3F;
    // Reset values
    localparam logic [5:0] RST_DIRECTION = 6'h3F;
    localparam logic [5:0] RST_LATCH = 6'h00;
    localparam logic [5:0] RST_ANALOG = 6'h17;
    localparam logic [5:0] RST_PULLUP = 6'h3F;
    localparam logic [5:0] RST_OPEN_DRAIN = 6'h00;
    localparam logic [5:0] RST_SLEW = 6'h37;
    localparam logic [5:0] RST_THRESHOLD = 6'h00;
    localparam logic RST_GLOBAL_PULLUP_DISABLE = 1'b1;
    // Field positions
    localparam int GPD_BIT = 0;
    localparam int MERGE_LSB = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        REG_PIN_VALUE, REG_DIRECTION, REG_OUTPUT_LATCH, REG_ANALOG_SELECT,
        REG_PULLUP_ENABLE, REG_OPEN_DRAIN, REG_SLEW_LIMIT,
        REG_INPUT_THRESHOLD, REG_PULLUP_CONTROL, REG_NONE
    } sgp_reg_t;

    // Pad-side controls, one bit per pin
    typedef struct packed {
        logic [5:0] pin_out;
        logic [5:0] pin_oe;
        logic [5:0] slew_limit;
        logic [5:0] input_threshold;
        logic [5:0] pullup_on;
        logic [5:0] analog_on;
    } sgp_pad_ctrl_t;
endpackage

// ==== core/sgp_port.sv ====
// Purpose: Six-bit general-purpose port with AXI4-Lite registers
// Assumes: Pad applies threshold, slew, pull-up and analog selection
// Notes: Pad outputs and bus outputs are registered
//
// Local design decisions: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
module sgp_port (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins
    input wire logic [5:0] pin_in,
    output sgp_pkg::sgp_pad_ctrl_t pad_ctrl,
    // Peripheral side
    input wire logic [5:0] periph_out_en,
    input wire logic [5:0] periph_out,
    output logic [5:0] periph_in
);
    logic [5:0] sync1_q, sync2_q, sync3_q, pin_lvl_q;
    logic [5:0] direction_q, latch_q, analog_q, pullup_q;
    logic [5:0] open_drain_q, slew_q, threshold_q;
    logic global_pullup_disable_q;
    logic [7:0] waddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic aw_got_q, w_got_q;
    logic do_write;
    logic [5:0] pin_digital;
    logic [5:0] merge_mask;
    logic [5:0] latch_d;
    logic [5:0] drive_val;
    sgp_pkg::sgp_reg_t wsel;
    sgp_pkg::sgp_reg_t rsel;
    logic [31:0] rd_word;

    function automatic sgp_pkg::sgp_reg_t reg_decode(input logic [7:0] a);
        sgp_pkg::sgp_reg_t r;
        case (a)
            sgp_pkg::OFS_PIN_VALUE: r = sgp_pkg::REG_PIN_VALUE;
            sgp_pkg::OFS_DIRECTION: r = sgp_pkg::REG_DIRECTION;
            sgp_pkg::OFS_OUTPUT_LATCH: r = sgp_pkg::REG_OUTPUT_LATCH;
            sgp_pkg::OFS_ANALOG_SELECT: r = sgp_pkg::REG_ANALOG_SELECT;
            sgp_pkg::OFS_PULLUP_ENABLE: r = sgp_pkg::REG_PULLUP_ENABLE;
            sgp_pkg::OFS_OPEN_DRAIN: r = sgp_pkg::REG_OPEN_DRAIN;
            sgp_pkg::OFS_SLEW_LIMIT: r = sgp_pkg::REG_SLEW_LIMIT;
            sgp_pkg::OFS_INPUT_THRESHOLD: r = sgp_pkg::REG_INPUT_THRESHOLD;
            sgp_pkg::OFS_PULLUP_CONTROL: r = sgp_pkg::REG_PULLUP_CONTROL;
            default: r = sgp_pkg::REG_NONE;
        endcase
        return r;
    endfunction

    // Input synchroniser; a level counts once stages two and three agree
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 6'h00;
            sync2_q <= 6'h00;
            sync3_q <= 6'h00;
            pin_lvl_q <= 6'h00;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
            for (int i = 0; i < sgp_pkg::NPIN; i++) begin
                if (sync2_q[i] == sync3_q[i]) begin
                    pin_lvl_q[i] <= sync3_q[i];
                end
            end
        end
    end

    // Analog-selected pins have no digital input; they read as zero
    assign pin_digital = pin_lvl_q & ~analog_q;

    // Peripherals see the thresholded, synchronised level
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            periph_in <= 6'h00;
        end else begin
            periph_in <= pin_digital;
        end
    end

    // Write channel: address and data taken in either order
    assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;
    assign wsel = reg_decode(waddr_q);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            waddr_q <= 8'h00;
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sgp_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                waddr_q <= s_axi_awaddr;
                aw_got_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                w_got_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (wsel == sgp_pkg::REG_NONE) ? sgp_pkg::RESP_SLVERR : sgp_pkg::RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Read-modify-write: bits outside the merge mask come from the pins
    always_comb begin
        if (!wstrb_q[0]) begin
            merge_mask = 6'h00;
        end else if (wstrb_q[1]) begin
            merge_mask = wdata_q[sgp_pkg::MERGE_LSB +: 6];
        end else begin
            merge_mask = sgp_pkg::MASK_ALL;
        end
        latch_d = ((wdata_q[5:0] & merge_mask) | (pin_digital & ~merge_mask)) & sgp_pkg::MASK_IO;
    end

    // Output latch
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            latch_q <= sgp_pkg::RST_LATCH;
        end else if (do_write && (wsel == sgp_pkg::REG_PIN_VALUE || wsel == sgp_pkg::REG_OUTPUT_LATCH)) begin
            latch_q <= latch_d;
        end
    end

    // Configuration registers; only byte lane 0 carries them
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            direction_q <= sgp_pkg::RST_DIRECTION;
            analog_q <= sgp_pkg::RST_ANALOG;
            pullup_q <= sgp_pkg::RST_PULLUP;
            open_drain_q <= sgp_pkg::RST_OPEN_DRAIN;
            slew_q <= sgp_pkg::RST_SLEW;
            threshold_q <= sgp_pkg::RST_THRESHOLD;
            global_pullup_disable_q <= sgp_pkg::RST_GLOBAL_PULLUP_DISABLE;
        end else if (do_write && wstrb_q[0]) begin
            unique case (wsel)
                sgp_pkg::REG_DIRECTION: begin
                    direction_q <= wdata_q[5:0] | ~sgp_pkg::MASK_IO;
                end
                sgp_pkg::REG_ANALOG_SELECT: begin
                    analog_q <= wdata_q[5:0] & sgp_pkg::MASK_ANALOG;
                end
                sgp_pkg::REG_PULLUP_ENABLE: begin
                    pullup_q <= wdata_q[5:0];
                end
                sgp_pkg::REG_OPEN_DRAIN: begin
                    open_drain_q <= wdata_q[5:0] & sgp_pkg::MASK_IO;
                end
                sgp_pkg::REG_SLEW_LIMIT: begin
                    slew_q <= wdata_q[5:0] & sgp_pkg::MASK_IO;
                end
                sgp_pkg::REG_INPUT_THRESHOLD: begin
                    threshold_q <= wdata_q[5:0];
                end
                sgp_pkg::REG_PULLUP_CONTROL: begin
                    global_pullup_disable_q <= wdata_q[sgp_pkg::GPD_BIT];
                end
                sgp_pkg::REG_PIN_VALUE, sgp_pkg::REG_OUTPUT_LATCH, sgp_pkg::REG_NONE: begin
                end
            endcase
        end
    end

    // Read channel
    assign rsel = reg_decode(s_axi_araddr);

    always_comb begin
        rd_word = 32'h00000000;
        unique case (rsel)
            sgp_pkg::REG_PIN_VALUE: rd_word[5:0] = pin_digital;
            sgp_pkg::REG_DIRECTION: rd_word[5:0] = direction_q;
            sgp_pkg::REG_OUTPUT_LATCH: rd_word[5:0] = latch_q;
            sgp_pkg::REG_ANALOG_SELECT: rd_word[5:0] = analog_q;
            sgp_pkg::REG_PULLUP_ENABLE: rd_word[5:0] = pullup_q;
            sgp_pkg::REG_OPEN_DRAIN: rd_word[5:0] = open_drain_q;
            sgp_pkg::REG_SLEW_LIMIT: rd_word[5:0] = slew_q;
            sgp_pkg::REG_INPUT_THRESHOLD: rd_word[5:0] = threshold_q;
            sgp_pkg::REG_PULLUP_CONTROL: rd_word[sgp_pkg::GPD_BIT] = global_pullup_disable_q;
            sgp_pkg::REG_NONE: rd_word = 32'h00000000;
        endcase
    end

    // Eight registers plus pull-up control, all in one map
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= sgp_pkg::RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= (rsel == sgp_pkg::REG_NONE) ? sgp_pkg::RESP_SLVERR : sgp_pkg::RESP_OKAY;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end

    // Peripheral overrides the latch where enabled; analog select plays no part
    assign drive_val = (periph_out_en & periph_out) | (~periph_out_en & latch_q);

    // Pad controls
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pad_ctrl <= '0;
        end else begin
            for (int i = 0; i < sgp_pkg::NPIN; i++) begin
                // Open drain releases the pin for a one
                pad_ctrl.pin_out[i] <= open_drain_q[i] ? 1'b0 : drive_val[i];
                pad_ctrl.pin_oe[i] <= !direction_q[i] && !(open_drain_q[i] && drive_val[i])
                    && (i != sgp_pkg::INPUT_ONLY_BIT);
                pad_ctrl.pullup_on[i] <= pullup_q[i] && direction_q[i] && !global_pullup_disable_q;
            end
            pad_ctrl.slew_limit <= slew_q;
            pad_ctrl.input_threshold <= threshold_q;
            pad_ctrl.analog_on <= analog_q;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/sgp_assertions.sv ====
// Purpose: Bus and pad checks for sgp_port
// Assumes: One clock, rst active high
// Notes: Attached by bind at the foot
`timescale 1ns/100ps
`default_nettype none
module sgp_assertions (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and peripheral
    input wire logic [5:0] pin_in,
    input wire sgp_pkg::sgp_pad_ctrl_t pad_ctrl,
    input wire logic [5:0] periph_out_en,
    input wire logic [5:0] periph_out,
    input wire logic [5:0] periph_in
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_pin3_undriven: assert property (!pad_ctrl.pin_oe[3])
        else $error("input-only pin driven");
    a_pullup_output_off: assert property ((pad_ctrl.pullup_on & pad_ctrl.pin_oe) == 6'h00)
        else $error("pull-up on driven pin");
    a_periph_wins: assert property (
        ((pad_ctrl.pin_oe & $past(periph_out_en)) & (pad_ctrl.pin_out ^ $past(periph_out))) == 6'h00)
        else $error("peripheral value not on pin");
    a_analog_zero: assert property ((periph_in & pad_ctrl.analog_on & $past(pad_ctrl.analog_on)) == 6'h00)
        else $error("analog pin read as one");
    a_input_synced: assert property (
        ($stable(pin_in) && $stable(pad_ctrl.analog_on)) [*6] |-> periph_in == (pin_in & ~pad_ctrl.analog_on))
        else $error("settled pin level not seen");
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write response missing");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data missing");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    c_write: cover property (s_axi_bvalid);
    c_stall: cover property (s_axi_rvalid && !s_axi_rready);
    c_periph: cover property (|(periph_out_en & pad_ctrl.pin_oe));
endmodule
bind sgp_port sgp_assertions u_sgp_assertions (.ref_clk(ref_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pin_in(pin_in),
    .pad_ctrl(pad_ctrl), .periph_out_en(periph_out_en), .periph_out(periph_out), .periph_in(periph_in));
`default_nettype wire

// ==== testbench/sgp_pin_model.sv ====
// Purpose: Board-side model of the six pins
// Assumes: Board drive never fights an enabled pad driver
// Notes: Undriven pins without pull-up wander each cycle
`timescale 1ns/100ps
`default_nettype none
module sgp_pin_model (
    // Clock
    input wire logic ref_clk,
    // Pad controls and board drive
    input wire sgp_pkg::sgp_pad_ctrl_t pad_ctrl,
    input wire logic [5:0] ext_en,
    input wire logic [5:0] ext_val,
    // Pin levels
    output logic [5:0] pin_in
);
    logic [5:0] float_q = 6'h2A;
    always @(posedge ref_clk) begin
        float_q <= ~float_q;
    end
    // Released open-drain pins float or follow the pull-up
    assign pin_in = (pad_ctrl.pin_oe & pad_ctrl.pin_out) | (~pad_ctrl.pin_oe & ext_en & ext_val)
        | (~pad_ctrl.pin_oe & ~ext_en & (pad_ctrl.pullup_on | float_q));
endmodule
`default_nettype wire

// ==== testbench/tb_sgp_port.sv ====
// Purpose: Register-level test of sgp_port
// Assumes: Pin 3 held high by the board
// Notes: Reads stall rready one cycle on purpose
`timescale 1ns/100ps
`default_nettype none
module tb_sgp_port;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic [31:0] d;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [1:0] r;
    // Write responses are always accepted, so bready stands high
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [5:0] periph_en = 6'h00;
    logic [5:0] periph_val = 6'h00;
    logic [5:0] pin_in;
    logic [5:0] pin_seen;
    sgp_pkg::sgp_pad_ctrl_t pad;
    int num_errors = 0;
    int total_checks = 0;
    logic [7:0] ra [8] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20};
    logic [31:0] rv [8] = '{32'h3F, 32'h0, 32'h17, 32'h3F, 32'h0, 32'h37, 32'h0, 32'h1};

    sgp_port dut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
        .pad_ctrl(pad), .periph_out_en(periph_en), .periph_out(periph_val), .periph_in(pin_seen));
    sgp_pin_model pins (.ref_clk(ref_clk), .pad_ctrl(pad), .ext_en(6'h08), .ext_val(6'h08), .pin_in(pin_in));

    initial begin
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s, input logic [1:0] e);
        int n;
        awaddr <= a;
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 50) check("write handshake", 32'h0, 32'h1);
        if (n == 50) finish_test();
        check("bresp", {30'h0, e}, {30'h0, bresp});
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge ref_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid && rready) break;
            rready <= rvalid;
        end
        if (n == 50) check("read handshake", 32'h0, 32'h1);
        if (n == 50) finish_test();
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask

    task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        rd(a);
        check(what, exp, d);
        check("rresp", 32'h0, {30'h0, r});
    endtask

    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 8; i++) rchk("reset value", ra[i], rv[i]);
        check("pull-up off", 32'h0, {26'h0, pad.pullup_on});
        wr(8'h24, 32'h0, 4'hF, 2'h2);
        rd(8'h24);
        check("unmapped rdata", 32'h0, d);
        check("unmapped rresp", 32'h2, {30'h0, r});
        wr(8'h04, 32'h0, 4'hF, 2'h0);
        rchk("direction", 8'h04, 32'h08);
        check("pin_oe", 32'h37, {26'h0, pad.pin_oe});
        wr(8'h0C, 32'h0, 4'hF, 2'h0);
        wr(8'h08, 32'h15, 4'h1, 2'h0);
        rchk("latch", 8'h08, 32'h15);
        repeat (6) @(posedge ref_clk);
        rchk("pins", 8'h00, 32'h1D);
        wr(8'h00, 32'h0202, 4'h3, 2'h0);
        rchk("merged latch", 8'h08, 32'h17);
        wr(8'h0C, 32'h01, 4'h1, 2'h0);
        repeat (6) @(posedge ref_clk);
        rchk("analog pins", 8'h00, 32'h1E);
        check("analog out", 32'h3, {30'h0, pad.pin_oe[0], pad.pin_out[0]});
        check("periph in", 32'h1E, {26'h0, pin_seen});
        wr(8'h00, 32'h0200, 4'h3, 2'h0);
        rchk("rmw latch", 8'h08, 32'h14);
        wr(8'h14, 32'h10, 4'h1, 2'h0);
        @(posedge ref_clk);
        check("od oe", 32'h27, {26'h0, pad.pin_oe});
        check("od out", 32'h04, {26'h0, pad.pin_out});
        wr(8'h14, 32'h0, 4'h1, 2'h0);
        wr(8'h20, 32'h0, 4'h1, 2'h0);
        wr(8'h04, 32'h30, 4'h1, 2'h0);
        rchk("direction", 8'h04, 32'h38);
        check("pull-up", 32'h38, {26'h0, pad.pullup_on});
        periph_en <= 6'h04;
        repeat (6) @(posedge ref_clk);
        check("periph out", 32'h10, {26'h0, pad.pin_out});
        rchk("pins", 8'h00, 32'h38);
        periph_en <= 6'h00;
        wr(8'h1C, 32'h2A, 4'h1, 2'h0);
        rchk("threshold", 8'h1C, 32'h2A);
        check("pad threshold", 32'h2A, {26'h0, pad.input_threshold});
        wr(8'h18, 32'h3F, 4'h1, 2'h0);
        rchk("slew", 8'h18, 32'h37);
        check("pad slew", 32'h37, {26'h0, pad.slew_limit});
        // Second reset in mid-run must restore the control values
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rchk("reset analog", 8'h0C, 32'h17);
        rchk("reset direction", 8'h04, 32'h3F);
        check("reset pin_oe", 32'h0, {26'h0, pad.pin_oe});
        finish_test();
    end
endmodule
`default_nettype wire
